// ### pkg/cpei_pkg.sv
// constants shared by the clock and power event interrupt block
// Notes on behaviour
// - periodic counter clock is rc or oscillator
// - in stop, count only in pseudo-stop on oscillator
// - period end sets flag, next period starts
// - periodic request only while its enable set
// - rate register write restarts the period
// - any lock change sets the lock flag
// - lock flag cleared only by writing one
// - lock request gated by enable, flag still set
// - oscillator-up zero when disabled, follows lock
// - any oscillator-up change sets its flag
// - lock loss or pll change drops oscillator-up
// - oscillator request only while its enable set
// - low-voltage status follows monitor in full performance
// - low-voltage change sets flag, enable gates request
// - high-temp status follows monitor in full performance
// - high-temp change sets flag, enable gates request
// - auto timer runs when enabled, selected clock
// - auto timer setup writes ignored while enabled
// - auto period end sets flag and restarts
// - wave pin driven when enabled and pin enabled
package cpei_pkg;

  localparam int unsigned NUM_FLAGS     = 6;
  localparam int unsigned FLAG_PERIODIC = 0;
  localparam int unsigned FLAG_LOCK     = 1;
  localparam int unsigned FLAG_OSC      = 2;
  localparam int unsigned FLAG_LOW_V    = 3;
  localparam int unsigned FLAG_HIGH_T   = 4;
  localparam int unsigned FLAG_AUTO     = 5;

  localparam int unsigned NUM_SYNC    = 7;
  localparam int unsigned NUM_CLK     = 3;
  localparam int unsigned SYNC_IRC    = 0;
  localparam int unsigned SYNC_OSC    = 1;
  localparam int unsigned SYNC_ACLK   = 2;
  localparam int unsigned SYNC_LOCK   = 3;
  localparam int unsigned SYNC_OSC_OK = 4;
  localparam int unsigned SYNC_LOW_V  = 5;
  localparam int unsigned SYNC_HIGH_T = 6;

  localparam int unsigned RTI_RATE_W   = 8;
  localparam int unsigned API_PERIOD_W = 16;

  localparam logic [7:0]  RTI_RATE_RST    = 8'h00;
  localparam logic [15:0] API_PERIOD_RST  = 16'h0000;
  localparam logic        API_CLK_SEL_RST = 1'h0;
  localparam logic [5:0]  FLAGS_RST       = 6'h00;

  localparam logic API_CLK_BUS = 1'h1;
  localparam logic RTI_SRC_OSC = 1'h1;

endpackage

// ### rtl/cpei_sync.sv
// three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cpei_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,   // bus clock
  input  wire logic         rst_i,   // synchronous reset, high
  input  wire logic [W-1:0] async_i, // levels from outside the domain
  output logic      [W-1:0] level_o  // filtered level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } cpei_sync_state_t;

  cpei_sync_state_t cur;
  cpei_sync_state_t next_cur;

  always_comb begin
    next_cur    = cur;
    next_cur.s1 = async_i;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    // s1 feeds only s2; a bit moves once s2 and s3 agree
    next_cur.lvl = (~(cur.s2 ^ cur.s3) & cur.s3) | ((cur.s2 ^ cur.s3) & cur.lvl);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign level_o = cur.lvl;

endmodule
`default_nettype wire

// ### rtl/cpei_top.sv
// event flags, timers and interrupt requests of the clock and power unit
`timescale 1ns/1ps
`default_nettype none
module cpei_top
  import cpei_pkg::*;
#(
  parameter int unsigned RATE_W   = RTI_RATE_W,
  parameter int unsigned PERIOD_W = API_PERIOD_W
) (
  input  wire logic                 CLK_I,                      // bus clock
  input  wire logic                 RST_I,                      // sync reset, high

  input  wire logic                 IRC_CLOCK_I,                // internal rc clock
  input  wire logic                 OSC_CLOCK_I,                // oscillator clock
  input  wire logic                 AUTO_CLOCK_I,               // autonomous clock
  input  wire logic                 LOCK_I,                     // pll lock detector
  input  wire logic                 OSC_QUALIFIED_I,            // oscillator good detector
  input  wire logic                 LOW_VOLTAGE_MON_I,          // supply monitor, 1 = low
  input  wire logic                 HIGH_TEMP_MON_I,            // temp monitor, 1 = hot

  input  wire logic                 STOP_MODE_I,                // stop mode active
  input  wire logic                 PSEUDO_STOP_SELECT_I,       // stop is pseudo-stop
  input  wire logic                 PSEUDO_STOP_ENABLE_I,       // keep counter in pseudo-stop
  input  wire logic                 FULL_STOP_MODE_I,           // full stop active
  input  wire logic                 FULL_PERFORMANCE_MODE_I,    // monitors valid
  input  wire logic                 BUS_CLOCK_STOPPED_I,        // bus clock gated off

  input  wire logic                 RTI_CLOCK_SELECT_I,         // 1 = oscillator
  input  wire logic                 PERIODIC_RATE_WR_I,         // rate write strobe
  input  wire logic [RATE_W-1:0]    PERIODIC_RATE_I,            // rate write data
  input  wire logic                 OSCILLATOR_ENABLE_I,        // oscillator enable
  input  wire logic                 PLL_CONFIG_WR_I,            // pll setup changed

  input  wire logic                 AUTO_TIMER_ENABLE_I,        // auto timer run
  input  wire logic                 AUTO_TIMER_CFG_WR_I,        // setup write strobe
  input  wire logic                 AUTO_TIMER_CLOCK_SELECT_I,  // 1 = bus clock
  input  wire logic [PERIOD_W-1:0]  AUTO_TIMER_PERIOD_I,        // period write data
  input  wire logic                 AUTO_TIMER_PIN_ENABLE_I,    // wave pin access

  input  wire logic                 PERIODIC_IRQ_ENABLE_I,      // enable
  input  wire logic                 LOCK_IRQ_ENABLE_I,          // enable
  input  wire logic                 OSCILLATOR_IRQ_ENABLE_I,    // enable
  input  wire logic                 LOW_VOLTAGE_IRQ_ENABLE_I,   // enable
  input  wire logic                 HIGH_TEMP_IRQ_ENABLE_I,     // enable
  input  wire logic                 AUTO_TIMER_IRQ_ENABLE_I,    // enable
  input  wire logic [NUM_FLAGS-1:0] FLAG_CLEAR_I,               // write-one-to-clear pulse

  output logic      [RATE_W-1:0]    PERIODIC_RATE_REG_O,        // stored rate
  output logic                      AUTO_TIMER_CLOCK_SELECT_O,  // stored clock select
  output logic      [PERIOD_W-1:0]  AUTO_TIMER_PERIOD_O,        // stored period
  output logic                      LOCK_STATUS_O,              // lock level
  output logic                      OSCILLATOR_UP_STATUS_O,     // oscillator up
  output logic                      LOW_VOLTAGE_STATUS_O,       // low voltage status
  output logic                      HIGH_TEMP_STATUS_O,         // high temp status
  output logic      [NUM_FLAGS-1:0] FLAGS_O,                    // sticky flags
  output logic                      PERIODIC_IRQ_O,             // request
  output logic                      LOCK_IRQ_O,                 // request
  output logic                      OSCILLATOR_IRQ_O,           // request
  output logic                      LOW_VOLTAGE_IRQ_O,          // request
  output logic                      HIGH_TEMP_IRQ_O,            // request
  output logic                      AUTO_TIMER_IRQ_O,           // request
  output logic                      AUTO_TIMER_WAVE_PIN_O       // timer waveform
);

  typedef struct packed {
    logic [NUM_CLK-1:0]   clk_prev;
    logic [RATE_W-1:0]    rate;
    logic [RATE_W-1:0]    rti_cnt;
    logic                 api_sel;
    logic [PERIOD_W-1:0]  api_period;
    logic [PERIOD_W-1:0]  api_cnt;
    logic                 wave;
    logic                 wave_pin;
    logic                 lock;
    logic                 wait_lock;
    logic                 osc_up;
    logic                 low_v;
    logic                 high_t;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] irq;
  } cpei_state_t;

  cpei_state_t          cur;
  cpei_state_t          next_cur;

  logic [NUM_SYNC-1:0]  raw_in;
  logic [NUM_SYNC-1:0]  sync_lvl;
  logic [NUM_CLK-1:0]   clk_rise;
  logic [NUM_FLAGS-1:0] set_ev;
  logic [NUM_FLAGS-1:0] irq_en;
  logic                 rti_tick;
  logic                 rti_run;
  logic                 api_tick;

  always_comb begin
    raw_in              = '0;
    raw_in[SYNC_IRC]    = IRC_CLOCK_I;
    raw_in[SYNC_OSC]    = OSC_CLOCK_I;
    raw_in[SYNC_ACLK]   = AUTO_CLOCK_I;
    raw_in[SYNC_LOCK]   = LOCK_I;
    raw_in[SYNC_OSC_OK] = OSC_QUALIFIED_I;
    raw_in[SYNC_LOW_V]  = LOW_VOLTAGE_MON_I;
    raw_in[SYNC_HIGH_T] = HIGH_TEMP_MON_I;
  end

  // timer clocks are sampled too, so they must stay well below half the bus rate
  cpei_sync #(
    .W (NUM_SYNC)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .async_i (raw_in),
    .level_o (sync_lvl)
  );

  always_comb begin
    irq_en                = '0;
    irq_en[FLAG_PERIODIC] = PERIODIC_IRQ_ENABLE_I;
    irq_en[FLAG_LOCK]     = LOCK_IRQ_ENABLE_I;
    irq_en[FLAG_OSC]      = OSCILLATOR_IRQ_ENABLE_I;
    irq_en[FLAG_LOW_V]    = LOW_VOLTAGE_IRQ_ENABLE_I;
    irq_en[FLAG_HIGH_T]   = HIGH_TEMP_IRQ_ENABLE_I;
    irq_en[FLAG_AUTO]     = AUTO_TIMER_IRQ_ENABLE_I;
  end

  always_comb begin
    next_cur = cur;
    set_ev   = '0;

    // edges only from filtered levels
    clk_rise          = sync_lvl[NUM_CLK-1:0] & ~cur.clk_prev;
    next_cur.clk_prev = sync_lvl[NUM_CLK-1:0];

    // periodic timer
    rti_tick = (RTI_CLOCK_SELECT_I == RTI_SRC_OSC) ? clk_rise[SYNC_OSC]
                                                   : clk_rise[SYNC_IRC];
    rti_run  = ~STOP_MODE_I
             | (PSEUDO_STOP_SELECT_I & (RTI_CLOCK_SELECT_I == RTI_SRC_OSC)
                & PSEUDO_STOP_ENABLE_I);

    if (PERIODIC_RATE_WR_I) begin
      next_cur.rate    = PERIODIC_RATE_I;
      next_cur.rti_cnt = '0;
    end else if ((cur.rate != '0) && rti_run && rti_tick) begin
      // rate zero leaves the counter parked
      if (cur.rti_cnt == RATE_W'(cur.rate - 1'b1)) begin
        next_cur.rti_cnt       = '0;
        set_ev[FLAG_PERIODIC] = 1'b1;
      end else begin
        next_cur.rti_cnt = RATE_W'(cur.rti_cnt + 1'b1);
      end
    end

    // lock change in either direction
    next_cur.lock = sync_lvl[SYNC_LOCK];
    if (next_cur.lock != cur.lock) begin
      set_ev[FLAG_LOCK] = 1'b1;
    end

    // a pll change holds the oscillator down until lock rises again;
    // relies on the lock detector really dropping after such a change
    if (PLL_CONFIG_WR_I) begin
      next_cur.wait_lock = 1'b1;
    end else if (next_cur.lock && !cur.lock) begin
      next_cur.wait_lock = 1'b0;
    end

    // uses the registered lock, so it comes up a cycle after lock
    next_cur.osc_up = OSCILLATOR_ENABLE_I
                    & ~FULL_STOP_MODE_I
                    & cur.lock
                    & next_cur.lock
                    & sync_lvl[SYNC_OSC_OK]
                    & ~cur.wait_lock
                    & ~PLL_CONFIG_WR_I;
    if (next_cur.osc_up != cur.osc_up) begin
      set_ev[FLAG_OSC] = 1'b1;
    end

    // monitors are only trusted in full performance mode
    if (FULL_PERFORMANCE_MODE_I) begin
      next_cur.low_v  = sync_lvl[SYNC_LOW_V];
      next_cur.high_t = sync_lvl[SYNC_HIGH_T];
    end
    if (next_cur.low_v != cur.low_v) begin
      set_ev[FLAG_LOW_V] = 1'b1;
    end
    if (next_cur.high_t != cur.high_t) begin
      set_ev[FLAG_HIGH_T] = 1'b1;
    end

    // auto timer setup only while stopped
    if (AUTO_TIMER_CFG_WR_I && !AUTO_TIMER_ENABLE_I) begin
      next_cur.api_sel    = AUTO_TIMER_CLOCK_SELECT_I;
      next_cur.api_period = AUTO_TIMER_PERIOD_I;
    end

    api_tick = (cur.api_sel == API_CLK_BUS) ? ~BUS_CLOCK_STOPPED_I
                                            : clk_rise[SYNC_ACLK];

    if (!AUTO_TIMER_ENABLE_I) begin
      // disabled timer restarts from zero when enabled again
      next_cur.api_cnt = '0;
      next_cur.wave    = 1'b0;
    end else if (api_tick) begin
      if (cur.api_cnt == cur.api_period) begin
        next_cur.api_cnt  = '0;
        next_cur.wave     = ~cur.wave;
        set_ev[FLAG_AUTO] = 1'b1;
      end else begin
        next_cur.api_cnt = PERIOD_W'(cur.api_cnt + 1'b1);
      end
    end

    next_cur.wave_pin = AUTO_TIMER_ENABLE_I & AUTO_TIMER_PIN_ENABLE_I
                      & next_cur.wave;

    // set beats a clear arriving in the same cycle
    next_cur.flags = (cur.flags & ~FLAG_CLEAR_I) | set_ev;
    next_cur.irq   = next_cur.flags & irq_en;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cur            <= '0;
      cur.rate       <= RATE_W'(RTI_RATE_RST);
      cur.api_period <= PERIOD_W'(API_PERIOD_RST);
      cur.api_sel    <= API_CLK_SEL_RST;
      cur.flags      <= FLAGS_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign PERIODIC_RATE_REG_O       = cur.rate;
  assign AUTO_TIMER_CLOCK_SELECT_O = cur.api_sel;
  assign AUTO_TIMER_PERIOD_O       = cur.api_period;
  assign LOCK_STATUS_O             = cur.lock;
  assign OSCILLATOR_UP_STATUS_O    = cur.osc_up;
  assign LOW_VOLTAGE_STATUS_O      = cur.low_v;
  assign HIGH_TEMP_STATUS_O        = cur.high_t;
  assign FLAGS_O                   = cur.flags;
  assign PERIODIC_IRQ_O            = cur.irq[FLAG_PERIODIC];
  assign LOCK_IRQ_O                = cur.irq[FLAG_LOCK];
  assign OSCILLATOR_IRQ_O          = cur.irq[FLAG_OSC];
  assign LOW_VOLTAGE_IRQ_O         = cur.irq[FLAG_LOW_V];
  assign HIGH_TEMP_IRQ_O           = cur.irq[FLAG_HIGH_T];
  assign AUTO_TIMER_IRQ_O          = cur.irq[FLAG_AUTO];
  assign AUTO_TIMER_WAVE_PIN_O     = cur.wave_pin;

endmodule
`default_nettype wire

// ### verification/cpei_props.sv
// port assertions for the clock and power event interrupt block
`timescale 1ns/1ps
`default_nettype none
module cpei_props
  import cpei_pkg::*;
#(
  parameter int unsigned RATE_W   = RTI_RATE_W,
  parameter int unsigned PERIOD_W = API_PERIOD_W
) (
  input wire logic CLK_I, RST_I, PLL_CONFIG_WR_I, OSCILLATOR_ENABLE_I, PERIODIC_RATE_WR_I,
  input wire logic FULL_PERFORMANCE_MODE_I, AUTO_TIMER_ENABLE_I, AUTO_TIMER_PIN_ENABLE_I,
  input wire logic PERIODIC_IRQ_ENABLE_I, LOCK_IRQ_ENABLE_I, OSCILLATOR_IRQ_ENABLE_I,
  input wire logic LOW_VOLTAGE_IRQ_ENABLE_I, HIGH_TEMP_IRQ_ENABLE_I, AUTO_TIMER_IRQ_ENABLE_I,
  input wire logic [RATE_W-1:0]    PERIODIC_RATE_I, PERIODIC_RATE_REG_O,
  input wire logic [PERIOD_W-1:0]  AUTO_TIMER_PERIOD_O,
  input wire logic [NUM_FLAGS-1:0] FLAG_CLEAR_I, FLAGS_O,
  input wire logic AUTO_TIMER_CLOCK_SELECT_O, LOCK_STATUS_O, OSCILLATOR_UP_STATUS_O,
  input wire logic LOW_VOLTAGE_STATUS_O, HIGH_TEMP_STATUS_O, PERIODIC_IRQ_O, LOCK_IRQ_O,
  input wire logic OSCILLATOR_IRQ_O, LOW_VOLTAGE_IRQ_O, HIGH_TEMP_IRQ_O, AUTO_TIMER_IRQ_O,
  input wire logic AUTO_TIMER_WAVE_PIN_O
);
  wire [5:0] irq = {AUTO_TIMER_IRQ_O, HIGH_TEMP_IRQ_O, LOW_VOLTAGE_IRQ_O, OSCILLATOR_IRQ_O,
                    LOCK_IRQ_O, PERIODIC_IRQ_O};
  wire [5:0] ena = {AUTO_TIMER_IRQ_ENABLE_I, HIGH_TEMP_IRQ_ENABLE_I, LOW_VOLTAGE_IRQ_ENABLE_I,
                    OSCILLATOR_IRQ_ENABLE_I, LOCK_IRQ_ENABLE_I, PERIODIC_IRQ_ENABLE_I};
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  lock_flag_a: assert property ($changed(LOCK_STATUS_O) |-> FLAGS_O[FLAG_LOCK])
    else $error("lock change left no flag");
  osc_flag_a: assert property ($changed(OSCILLATOR_UP_STATUS_O) |-> FLAGS_O[FLAG_OSC])
    else $error("oscillator change left no flag");
  low_flag_a: assert property ($changed(LOW_VOLTAGE_STATUS_O) |-> FLAGS_O[FLAG_LOW_V])
    else $error("low voltage change left no flag");
  hot_flag_a: assert property ($changed(HIGH_TEMP_STATUS_O) |-> FLAGS_O[FLAG_HIGH_T])
    else $error("high temp change left no flag");
  irq_gate_a: assert property (irq == (FLAGS_O & $past(ena)))
    else $error("request differs from flag and enable");
  flag_hold_a: assert property (1'b1 |=>
    (FLAGS_O & $past(FLAGS_O & ~FLAG_CLEAR_I)) == $past(FLAGS_O & ~FLAG_CLEAR_I))
    else $error("flag dropped without clear");
  osc_off_a: assert property (!OSCILLATOR_ENABLE_I |=> !OSCILLATOR_UP_STATUS_O)
    else $error("oscillator up while disabled");
  osc_order_a: assert property ($rose(OSCILLATOR_UP_STATUS_O) |-> $past(LOCK_STATUS_O))
    else $error("oscillator up before lock");
  pll_drop_a: assert property (PLL_CONFIG_WR_I |=> !OSCILLATOR_UP_STATUS_O)
    else $error("oscillator up kept after pll change");
  rate_load_a: assert property (PERIODIC_RATE_WR_I |=>
    PERIODIC_RATE_REG_O == $past(PERIODIC_RATE_I))
    else $error("rate not stored");
  cfg_lock_a: assert property (AUTO_TIMER_ENABLE_I |=>
    $stable(AUTO_TIMER_PERIOD_O) && $stable(AUTO_TIMER_CLOCK_SELECT_O))
    else $error("auto setup changed while running");
  wave_off_a: assert property (
    !(AUTO_TIMER_ENABLE_I && AUTO_TIMER_PIN_ENABLE_I) |=> !AUTO_TIMER_WAVE_PIN_O)
    else $error("wave pin driven without access");
  mon_hold_a: assert property (!FULL_PERFORMANCE_MODE_I |=>
    $stable({LOW_VOLTAGE_STATUS_O, HIGH_TEMP_STATUS_O}))
    else $error("monitor status moved outside full performance");
  rti_off_a: assert property ($rose(FLAGS_O[FLAG_PERIODIC]) |->
    $past(PERIODIC_RATE_REG_O) != 0)
    else $error("periodic flag with rate off");
  auto_run_a: assert property ($rose(FLAGS_O[FLAG_AUTO]) |-> $past(AUTO_TIMER_ENABLE_I))
    else $error("auto flag while disabled");
  cover property ($rose(FLAGS_O[FLAG_PERIODIC]));
  cover property ($rose(AUTO_TIMER_WAVE_PIN_O));
  cover property ($fell(OSCILLATOR_UP_STATUS_O));
endmodule
bind cpei_top cpei_props #(.RATE_W(RATE_W), .PERIOD_W(PERIOD_W)) u_props (.*);
`default_nettype wire

// ### verification/cpei_top_tb.sv
// self-checking bench for the clock and power event interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
module cpei_top_tb
  import cpei_pkg::*;
;
  logic CLK_I, RST_I, IRC_CLOCK_I, OSC_CLOCK_I, AUTO_CLOCK_I, LOCK_I, OSC_QUALIFIED_I;
  logic LOW_VOLTAGE_MON_I, HIGH_TEMP_MON_I, STOP_MODE_I, PSEUDO_STOP_SELECT_I;
  logic PSEUDO_STOP_ENABLE_I, FULL_STOP_MODE_I, FULL_PERFORMANCE_MODE_I, BUS_CLOCK_STOPPED_I;
  logic RTI_CLOCK_SELECT_I, PERIODIC_RATE_WR_I, OSCILLATOR_ENABLE_I, PLL_CONFIG_WR_I;
  logic AUTO_TIMER_ENABLE_I, AUTO_TIMER_CFG_WR_I, AUTO_TIMER_CLOCK_SELECT_I;
  logic AUTO_TIMER_PIN_ENABLE_I, AUTO_TIMER_CLOCK_SELECT_O, LOCK_STATUS_O;
  logic OSCILLATOR_UP_STATUS_O, LOW_VOLTAGE_STATUS_O, HIGH_TEMP_STATUS_O, PERIODIC_IRQ_O;
  logic LOCK_IRQ_O, OSCILLATOR_IRQ_O, LOW_VOLTAGE_IRQ_O, HIGH_TEMP_IRQ_O, AUTO_TIMER_IRQ_O;
  logic AUTO_TIMER_WAVE_PIN_O;
  logic [7:0]  PERIODIC_RATE_I, PERIODIC_RATE_REG_O;
  logic [15:0] AUTO_TIMER_PERIOD_I, AUTO_TIMER_PERIOD_O;
  logic [5:0]  FLAG_CLEAR_I, FLAGS_O, en, exp_flags;
  wire         PERIODIC_IRQ_ENABLE_I, LOCK_IRQ_ENABLE_I, OSCILLATOR_IRQ_ENABLE_I;
  wire         LOW_VOLTAGE_IRQ_ENABLE_I, HIGH_TEMP_IRQ_ENABLE_I, AUTO_TIMER_IRQ_ENABLE_I;
  wire [5:0]   irqs = {AUTO_TIMER_IRQ_O, HIGH_TEMP_IRQ_O, LOW_VOLTAGE_IRQ_O, OSCILLATOR_IRQ_O,
                       LOCK_IRQ_O, PERIODIC_IRQ_O};
  int          n_errors = 0, tests_run = 0, seed = 40734, rate, per, n;
  localparam logic [1:0] st [4] = '{2'h1, 2'h3, 2'h3, 2'h0};
  localparam logic [5:0] fl [4] = '{6'h08, 6'h10, 6'h00, 6'h18};
  assign {AUTO_TIMER_IRQ_ENABLE_I, HIGH_TEMP_IRQ_ENABLE_I, LOW_VOLTAGE_IRQ_ENABLE_I,
          OSCILLATOR_IRQ_ENABLE_I, LOCK_IRQ_ENABLE_I, PERIODIC_IRQ_ENABLE_I} = en;
  cpei_top DUT (.*);
  always #25 CLK_I = ~CLK_I;
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK_I);
  endtask
  task automatic conclude();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check_all();
    `CHK(FLAGS_O, exp_flags)
    `CHK(irqs, exp_flags & en)
  endtask
  task automatic clear(input logic [5:0] m);
    @(posedge CLK_I);
    FLAG_CLEAR_I <= m;
    @(posedge CLK_I);
    FLAG_CLEAR_I <= 6'h00;
    exp_flags &= ~m;
  endtask
  // slow pulse so the sampled clock survives the filter
  // 0 rc clock, 1 oscillator clock, 2 autonomous clock
  task automatic tick(input int s);
    @(posedge CLK_I);
    if (s == 2) AUTO_CLOCK_I <= 1;
    else if (s == 1) OSC_CLOCK_I <= 1;
    else IRC_CLOCK_I <= 1;
    cyc(6);
    {AUTO_CLOCK_I, IRC_CLOCK_I, OSC_CLOCK_I} <= 3'h0;
    cyc(6);
  endtask
  task automatic wr_rate();
    @(posedge CLK_I);
    PERIODIC_RATE_WR_I <= 1;
    PERIODIC_RATE_I <= 8'(rate);
    @(posedge CLK_I);
    PERIODIC_RATE_WR_I <= 0;
  endtask
  initial begin
    cyc(6000);
    n_errors++;
    conclude();
  end
  initial begin
    {CLK_I, IRC_CLOCK_I, OSC_CLOCK_I, AUTO_CLOCK_I, LOCK_I, OSC_QUALIFIED_I, LOW_VOLTAGE_MON_I,
     HIGH_TEMP_MON_I, STOP_MODE_I, PSEUDO_STOP_SELECT_I, PSEUDO_STOP_ENABLE_I, FULL_STOP_MODE_I,
     FULL_PERFORMANCE_MODE_I, BUS_CLOCK_STOPPED_I, RTI_CLOCK_SELECT_I, PERIODIC_RATE_WR_I,
     OSCILLATOR_ENABLE_I, PLL_CONFIG_WR_I, AUTO_TIMER_ENABLE_I, AUTO_TIMER_CFG_WR_I,
     AUTO_TIMER_CLOCK_SELECT_I, AUTO_TIMER_PIN_ENABLE_I, en, PERIODIC_RATE_I,
     AUTO_TIMER_PERIOD_I, FLAG_CLEAR_I, exp_flags} = '0;
    RST_I = 1;
    cyc(10);
    RST_I <= 0;
    en <= 6'($random(seed)) | 6'h02;
    {OSC_QUALIFIED_I, OSCILLATOR_ENABLE_I, LOCK_I, FULL_PERFORMANCE_MODE_I} <= 4'hF;
    cyc(1);
    #1;
    `CHK({PERIODIC_RATE_REG_O, AUTO_TIMER_PERIOD_O, AUTO_TIMER_CLOCK_SELECT_O}, 25'h0)
    cyc(8);
    #1;
    exp_flags = 6'h06;
    `CHK({LOCK_STATUS_O, OSCILLATOR_UP_STATUS_O}, 2'h3)
    check_all();
    clear(6'h00);
    cyc(1);
    #1;
    check_all();
    clear(6'h02);
    cyc(1);
    #1;
    check_all();
    clear(6'h04);
    en[1] <= 0;
    LOCK_I <= 0;
    cyc(8);
    #1;
    exp_flags = 6'h06;
    `CHK({LOCK_STATUS_O, OSCILLATOR_UP_STATUS_O}, 2'h0)
    check_all();
    LOCK_I <= 1;
    cyc(8);
    clear(6'h06);
    for (int s = 0; s < 5; s++) begin
      @(posedge CLK_I);
      if (s == 4) PLL_CONFIG_WR_I <= 1;
      else if (s > 1) FULL_STOP_MODE_I <= !s[0];
      else OSCILLATOR_ENABLE_I <= s[0];
      @(posedge CLK_I);
      PLL_CONFIG_WR_I <= 0;
      cyc(8);
      #1;
      exp_flags = 6'h04;
      `CHK(OSCILLATOR_UP_STATUS_O, s[0])
      check_all();
      clear(6'h04);
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge CLK_I);
      FULL_PERFORMANCE_MODE_I <= (m != 2);
      LOW_VOLTAGE_MON_I <= (m < 2);
      HIGH_TEMP_MON_I <= (m == 1);
      cyc(8);
      #1;
      exp_flags = exp_flags | fl[m];
      `CHK({HIGH_TEMP_STATUS_O, LOW_VOLTAGE_STATUS_O}, st[m])
      check_all();
      clear(6'h18);
    end
    rate = 2 + ($random(seed) & 3);
    PSEUDO_STOP_SELECT_I <= 1;
    PSEUDO_STOP_ENABLE_I <= 1;
    for (int p = 0; p < 4; p++) begin
      @(posedge CLK_I);
      RTI_CLOCK_SELECT_I <= p[0];
      STOP_MODE_I <= p[1];
      wr_rate();
      repeat (rate - 1) tick(p[0]);
      wr_rate();
      repeat (rate - 1) tick(p[0]);
      tick(!p[0]);
      #1;
      check_all();
      tick(p[0]);
      #1;
      exp_flags[0] = !p[1] || p[0];
      `CHK(PERIODIC_RATE_REG_O, 8'(rate))
      check_all();
      clear(6'h01);
    end
    STOP_MODE_I <= 0;
    per = 1 + ($random(seed) & 7);
    @(posedge CLK_I);
    AUTO_TIMER_CFG_WR_I <= 1;
    AUTO_TIMER_CLOCK_SELECT_I <= API_CLK_BUS;
    AUTO_TIMER_PERIOD_I <= 16'(per);
    AUTO_TIMER_PIN_ENABLE_I <= 1;
    @(posedge CLK_I);
    AUTO_TIMER_CFG_WR_I <= 0;
    AUTO_TIMER_ENABLE_I <= 1;
    n = 0;
    while (n < 40 && FLAGS_O[5] !== 1'b1) begin
      @(posedge CLK_I);
      #1;
      n++;
    end
    `CHK(n, per + 1)
    `CHK(AUTO_TIMER_WAVE_PIN_O, 1'b1)
    @(posedge CLK_I);
    AUTO_TIMER_CFG_WR_I <= 1;
    AUTO_TIMER_PERIOD_I <= ~16'(per);
    AUTO_TIMER_CLOCK_SELECT_I <= 0;
    @(posedge CLK_I);
    AUTO_TIMER_CFG_WR_I <= 0;
    cyc(1);
    #1;
    `CHK({AUTO_TIMER_CLOCK_SELECT_O, AUTO_TIMER_PERIOD_O}, {API_CLK_BUS, 16'(per)})
    exp_flags[5] = 1;
    check_all();
    @(posedge CLK_I);
    BUS_CLOCK_STOPPED_I <= 1;
    clear(6'h20);
    cyc(20);
    #1;
    check_all();
    @(posedge CLK_I);
    BUS_CLOCK_STOPPED_I <= 0;
    AUTO_TIMER_PIN_ENABLE_I <= 0;
    cyc(3);
    #1;
    `CHK(AUTO_TIMER_WAVE_PIN_O, 1'b0)
    @(posedge CLK_I);
    AUTO_TIMER_ENABLE_I <= 0;
    @(posedge CLK_I);
    AUTO_TIMER_CFG_WR_I <= 1;
    AUTO_TIMER_CLOCK_SELECT_I <= 0;
    AUTO_TIMER_PERIOD_I <= 16'h0001;
    @(posedge CLK_I);
    AUTO_TIMER_CFG_WR_I <= 0;
    AUTO_TIMER_ENABLE_I <= 1;
    clear(6'h20);
    // autonomous clock path: period 1 needs two ticks
    tick(2);
    #1;
    check_all();
    tick(2);
    #1;
    exp_flags[5] = 1;
    check_all();
    conclude();
  end
endmodule
`default_nettype wire
